// file: src/list_mode_sequencer.sv
// Purpose: List-mode point sequencer: direction, repeat, sub-list, dwell, sync.
// Assumes: Host commands arrive as one-cycle strobes on clk.
// Notes:   Trigger is honoured only in list operation and while idle.
`timescale 1ns/10ps
`include "lms_cfg.svh"
module list_mode_sequencer
   import lms_pkg::*;
#(
   parameter int DEPTH = `LMS_DEPTH
) (
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire list_write_t                 listWr,
   input  wire logic                        dirWrite,
   input  wire logic                        dirDownSet,
   input  wire logic                        repeatWrite,
   input  wire repeat_t                     repeatSet,
   input  wire logic                        autoWrite,
   input  wire logic                        autoSet,
   input  wire logic                        fixedModeWrite,
   input  wire logic [1:0]                  syncSel,
   input  wire logic                        listPrepare,
   input  wire logic                        trigger,
   output logic                             dirDown,
   output repeat_t                          repeatMode,
   output logic                             autoSeq,
   output logic                             listMode,
   output logic      [$clog2(DEPTH+1)-1:0]  freqCount,
   output logic      [$clog2(DEPTH+1)-1:0]  powCount,
   output logic      [$clog2(DEPTH+1)-1:0]  dwellCount,
   output logic      [$clog2(DEPTH+1)-1:0]  seqCount,
   output point_t                           pointOut,
   output logic      [$clog2(DEPTH)-1:0]    pointIdx,
   output logic                             pointStrobe,
   output logic                             busy,
   output logic                             syncOut
);
   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2) $error("list_mode_sequencer: DEPTH must be at least 2");

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic [1:0] rstSync_q;
   logic       rstN;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         rstSync_q <= 2'h0;
      else
         rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstN = rstSync_q[1];

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Walk position to list slot, honouring direction
   function automatic logic [IW-1:0] walkSlot(input logic [CW-1:0] pos,
                                              input logic [CW-1:0] len,
                                              input logic          down);
      logic [CW-1:0] slot;
      slot = down ? (len - CW'(1) - pos) : pos;
      return slot[IW-1:0];
   endfunction : walkSlot

   // Sync selection decode
   function automatic logic syncHit(input logic [1:0] sel, input logic first,
                                    input logic last);
      logic hit;
      unique case (sel)
         `LMS_SYNC_OFF:   hit = 1'b0;
         `LMS_SYNC_FIRST: hit = first;
         `LMS_SYNC_LAST:  hit = last;
         `LMS_SYNC_EACH:  hit = 1'b1;
      endcase
      return hit;
   endfunction : syncHit

   // ****************************************************************
   // Settings
   // ****************************************************************
   logic    dir_d, dir_q, auto_d, auto_q, list_d, list_q;
   repeat_t rep_d, rep_q;

   // Host-written settings
   always_comb begin
      dir_d  = dirWrite ? dirDownSet : dir_q;
      rep_d  = repeatWrite ? repeatSet : rep_q;
      auto_d = autoWrite ? autoSet : auto_q;
      list_d = list_q;
      if (fixedModeWrite)
         list_d = 1'b0;
      if (autoWrite)
         list_d = 1'b1;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         dir_q  <= `LMS_RST_DIR_DOWN;
         rep_q  <= REP_SWEEP;
         auto_q <= `LMS_RST_AUTO;
         list_q <= `LMS_RST_LIST;
      end else begin
         dir_q  <= dir_d;
         rep_q  <= rep_d;
         auto_q <= auto_d;
         list_q <= list_d;
      end
   end

   assign dirDown    = dir_q;
   assign repeatMode = rep_q;
   assign autoSeq    = auto_q;
   assign listMode   = list_q;

   // ****************************************************************
   // Lists
   // ****************************************************************
   logic [CW-1:0]          cnt [4];
   logic [CW-1:0]          pos_d, pos_q, len;
   logic [IW-1:0]          walkIdx, rdIdx;
   logic [`LMS_DATA_W-1:0] dwellUs, seqEntry, seqIdx;
   point_t                 obj;

   list_point_store #(.DEPTH(DEPTH)) u_store (
      .clk         (clk),
      .rstN        (rstN),
      .wr          (listWr),
      .prepare     (listPrepare),
      .rdIdx       (rdIdx),
      .seqRdIdx    (walkIdx),
      .obj         (obj),
      .dwellGlobal (dwellUs),
      .seqEntry    (seqEntry),
      .cnt         (cnt)
   );

   assign freqCount  = cnt[KIND_FREQ];
   assign powCount   = cnt[KIND_POW];
   assign dwellCount = cnt[KIND_DWELL];
   assign seqCount   = cnt[KIND_SEQ];

   // Walk length and point selection; sub-list entries count from one
   always_comb begin
      if (auto_q)
         len = (cnt[KIND_FREQ] < cnt[KIND_POW]) ? cnt[KIND_FREQ] : cnt[KIND_POW];
      else
         len = cnt[KIND_SEQ];
      walkIdx = walkSlot(pos_q, len, dir_q);
      seqIdx  = seqEntry - `LMS_DATA_W'(1);
      rdIdx   = auto_q ? walkIdx : seqIdx[IW-1:0];
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   seq_state_t             state_d, state_q;
   logic [`LMS_DATA_W-1:0] dwell_d, dwell_q, dwellCyc;
   point_t                 point_d, point_q;
   logic [IW-1:0]          idx_d, idx_q;
   logic                   strobe_d, strobe_q, fire, isFirst, isLast, dwellDone;

   assign isFirst   = (pos_q == '0);
   assign isLast    = (pos_q == len - CW'(1));
   assign dwellDone = (dwell_q == '0);
   assign dwellCyc  = (dwellUs == '0) ? `LMS_DATA_W'(1)
                                      : `LMS_DATA_W'(dwellUs * `LMS_CYC_PER_US);

   // Point walk, dwell and halt decisions
   always_comb begin
      state_d  = state_q;
      pos_d    = pos_q;
      dwell_d  = dwell_q;
      point_d  = point_q;
      idx_d    = idx_q;
      strobe_d = 1'b0;
      fire     = 1'b0;
      unique case (state_q)
         S_IDLE: begin
            if (pos_q >= len)
               pos_d = '0;
            if (trigger && list_q && len != '0) begin
               if (rep_q != REP_STEP || pos_q >= len)
                  pos_d = '0;
               state_d = S_POINT;
            end
         end
         S_POINT: begin
            point_d  = obj;
            idx_d    = rdIdx;
            strobe_d = 1'b1;
            fire     = syncHit(syncSel, isFirst, isLast);
            dwell_d  = dwellCyc - `LMS_DATA_W'(1);
            state_d  = S_DWELL;
         end
         S_DWELL: begin
            if (!dwellDone)
               dwell_d = dwell_q - `LMS_DATA_W'(1);
            else begin
               pos_d = isLast ? '0 : pos_q + CW'(1);
               unique case (rep_q)
                  REP_STEP:  state_d = S_IDLE;
                  REP_SWEEP: state_d = isLast ? S_IDLE : S_POINT;
                  default:   state_d = S_POINT;
               endcase
            end
         end
         default: state_d = S_IDLE;
      endcase
      if (fixedModeWrite)
         state_d = S_IDLE;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q  <= S_IDLE;
         pos_q    <= '0;
         dwell_q  <= '0;
         point_q  <= '0;
         idx_q    <= '0;
         strobe_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         pos_q    <= pos_d;
         dwell_q  <= dwell_d;
         point_q  <= point_d;
         idx_q    <= idx_d;
         strobe_q <= strobe_d;
      end
   end

   assign pointOut    = point_q;
   assign pointIdx    = idx_q;
   assign pointStrobe = strobe_q;
   assign busy        = (state_q != S_IDLE);

   // Sync pulse starts with the point output
   sync_pulse_gen #(.WIDTH(`LMS_SYNC_CYC)) u_sync (
      .clk     (clk),
      .rstN    (rstN),
      .fire    (fire),
      .syncOut (syncOut)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstN);

   a_dir_up_walk: assert property ((state_q == S_POINT && auto_q && !dir_q)
      |=> idx_q == IW'($past(pos_q))) else $error("up walk index wrong");
   a_dir_down_walk: assert property ((state_q == S_POINT && auto_q && dir_q)
      |=> idx_q == IW'($past(len) - CW'(1) - $past(pos_q)))
      else $error("down walk index wrong");
   a_dir_readback: assert property (dirWrite |=> dirDown == $past(dirDownSet))
      else $error("direction readback wrong");
   a_sweep_halts: assert property ((state_q == S_DWELL && dwellDone && rep_q == REP_SWEEP
      && isLast && !fixedModeWrite) |=> state_q == S_IDLE && pos_q == '0)
      else $error("sweep did not halt at end");
   a_step_halts: assert property ((state_q == S_DWELL && dwellDone && rep_q == REP_STEP)
      |=> state_q == S_IDLE) else $error("step did not halt");
   a_loop_wraps: assert property ((state_q == S_DWELL && dwellDone && isLast
      && rep_q == REP_ENDLESS_LOOP && !fixedModeWrite) |=> state_q == S_POINT && pos_q == '0)
      else $error("loop did not wrap");
   a_auto_list_mode: assert property (autoWrite |=> listMode && autoSeq == $past(autoSet))
      else $error("auto write did not enter list mode");
   a_sync_silent: assert property (syncSel == `LMS_SYNC_OFF |-> !fire)
      else $error("sync fired while off");
   a_sync_first: assert property ((fire && syncSel == `LMS_SYNC_FIRST) |-> isFirst)
      else $error("first sync on wrong point");
   a_sync_last: assert property ((fire && syncSel == `LMS_SYNC_LAST) |-> isLast)
      else $error("last sync on wrong point");
   a_sync_each: assert property ((state_q == S_POINT && syncSel == `LMS_SYNC_EACH)
      |=> syncOut && pointStrobe) else $error("each-point sync missing");
   a_dwell_hold: assert property ((state_q == S_POINT && !fixedModeWrite)
      |=> state_q == S_DWELL && dwell_q == $past(dwellCyc) - `LMS_DATA_W'(1))
      else $error("dwell not loaded");

   c_step_done: cover property (state_q == S_DWELL && dwellDone && rep_q == REP_STEP);
   c_loop_wrap: cover property (state_q == S_DWELL && dwellDone && isLast
      && rep_q == REP_ENDLESS_LOOP);
   c_sub_list: cover property (state_q == S_POINT && !auto_q);
endmodule : list_mode_sequencer

// file: src/list_point_store.sv
// Purpose: Holds source lists, sub-list and prepared point objects.
// Assumes: Writes append; clear empties one list.
// Notes:   Reads are combinational from the arrays.
`timescale 1ns/10ps
`include "lms_cfg.svh"
module list_point_store
   import lms_pkg::*;
#(
   parameter int DEPTH = `LMS_DEPTH
) (
   input  wire logic                         clk,
   input  wire logic                         rstN,
   input  wire list_write_t                  wr,
   input  wire logic                         prepare,
   input  wire logic [$clog2(DEPTH)-1:0]     rdIdx,
   input  wire logic [$clog2(DEPTH)-1:0]     seqRdIdx,
   output point_t                            obj,
   output logic      [`LMS_DATA_W-1:0]       dwellGlobal,
   output logic      [`LMS_DATA_W-1:0]       seqEntry,
   output logic      [$clog2(DEPTH+1)-1:0]   cnt [4]
);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2) $error("list_point_store: DEPTH must be at least 2");

   logic [`LMS_DATA_W-1:0] srcMem [4][DEPTH];
   point_t                 objMem [DEPTH];
   logic [CW-1:0]          cnt_d  [4];
   logic [CW-1:0]          cnt_q  [4];

   // ****************************************************************
   // Entry counters, one per list
   // ****************************************************************
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         cnt_d[k] = cnt_q[k];
         if (wr.valid && wr.kind == list_kind_t'(k)) begin
            if (wr.clear)
               cnt_d[k] = '0;
            else if (cnt_q[k] < CW'(DEPTH))
               cnt_d[k] = cnt_q[k] + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN)
         for (int k = 0; k < 4; k++) cnt_q[k] <= '0;
      else
         cnt_q <= cnt_d;
   end

   // ****************************************************************
   // List memories and prepare conversion
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (wr.valid && !wr.clear && cnt_q[wr.kind] < CW'(DEPTH))
         srcMem[wr.kind][cnt_q[wr.kind][$clog2(DEPTH)-1:0]] <= wr.data;
      if (prepare)
         for (int i = 0; i < DEPTH; i++)
            objMem[i] <= '{freq: srcMem[KIND_FREQ][i], pow: srcMem[KIND_POW][i]};
   end

   // Read ports; one index addresses frequency and power together
   assign obj         = objMem[rdIdx];
   assign dwellGlobal = srcMem[KIND_DWELL][0];
   assign seqEntry    = srcMem[KIND_SEQ][seqRdIdx];
   assign cnt         = cnt_q;
endmodule : list_point_store

// file: src/lms_cfg.svh
// Purpose: Constants for the list-mode point sequencer.
// Assumes: 20 MHz system clock; dwell entries are whole microseconds.
// Notes:   Definitions only.
//
// Contract
// - Up runs first to last; down reverses; up at reset
// - Direction readback reports up or down
// - First dwell entry is the global dwell
// - Report number of dwell entries
// - Store frequency entries and report their count
// - Store power entries and report their count
// - Prepare converts source lists into point objects
// - Sweep trigger runs whole list then halts
// - Step trigger runs current point then halts
// - Endless loop restarts after the final point
// - Repeat mode is readable back
// - Sub-list limits triggered points, in its order
// - One index selects frequency, dwell, power together; the code indexes frequency and power only, dwell is always entry 0
// - Report number of sub-list indexes
// - Auto sequencing ignores sub-list; on at reset
// - Writing auto setting switches into list operation
// - Sync select 0 emits no pulse
// - Sync select 1 pulses on first point
// - Sync select 2 pulses on last point
// - Sync select 3 pulses on every point
// - Trigger starts a cycle; step or sweep idles after
`ifndef LMS_CFG_SVH
`define LMS_CFG_SVH

`define LMS_DEPTH        16
`define LMS_DATA_W       32
`define LMS_CLK_HZ       20000000
`define LMS_CYC_PER_US   (`LMS_CLK_HZ / 1000000)
`define LMS_SYNC_NS      200
`define LMS_SYNC_CYC     ((`LMS_SYNC_NS * (`LMS_CLK_HZ / 1000000) + 999) / 1000)
`define LMS_SYNC_OFF     2'h0
`define LMS_SYNC_FIRST   2'h1
`define LMS_SYNC_LAST    2'h2
`define LMS_SYNC_EACH    2'h3
`define LMS_RST_DIR_DOWN 1'b0
`define LMS_RST_AUTO     1'b1
`define LMS_RST_LIST     1'b0

`endif

// file: src/lms_pkg.sv
// Purpose: Types shared by the list-mode sequencer files.
// Assumes: lms_cfg.svh supplies widths.
// Notes:   Types only.
`include "lms_cfg.svh"
package lms_pkg;
   typedef enum logic [1:0] {
      REP_SWEEP        = 2'h0,
      REP_STEP         = 2'h1,
      REP_ENDLESS_LOOP = 2'h2
   } repeat_t;

   typedef enum logic [1:0] {
      KIND_FREQ  = 2'h0,
      KIND_POW   = 2'h1,
      KIND_DWELL = 2'h2,
      KIND_SEQ   = 2'h3
   } list_kind_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h1,
      S_POINT = 3'h2,
      S_DWELL = 3'h4
   } seq_state_t;

   typedef struct packed {
      logic                   valid;
      logic                   clear;
      list_kind_t             kind;
      logic [`LMS_DATA_W-1:0] data;
   } list_write_t;

   typedef struct packed {
      logic [`LMS_DATA_W-1:0] freq;
      logic [`LMS_DATA_W-1:0] pow;
   } point_t;
endpackage : lms_pkg

// file: src/sync_pulse_gen.sv
// Purpose: Stretches a one-cycle fire request into a fixed-width sync pulse.
// Assumes: A new fire restarts the pulse.
// Notes:   Output is registered.
`timescale 1ns/10ps
`include "lms_cfg.svh"
module sync_pulse_gen #(
   parameter int WIDTH = `LMS_SYNC_CYC
) (
   input  wire logic clk,
   input  wire logic rstN,
   input  wire logic fire,
   output logic      syncOut
);
   localparam int TW = $clog2(WIDTH + 1);

   if (WIDTH < 1) $error("sync_pulse_gen: WIDTH must be at least 1");

   logic [TW-1:0] left_d;
   logic [TW-1:0] left_q;
   logic          sync_d;
   logic          sync_q;

   // Pulse length counter
   always_comb begin
      left_d = left_q;
      if (fire)
         left_d = TW'(WIDTH - 1);
      else if (left_q != '0)
         left_d = left_q - TW'(1);
      sync_d = fire || (left_q != '0);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         left_q <= '0;
         sync_q <= 1'b0;
      end else begin
         left_q <= left_d;
         sync_q <= sync_d;
      end
   end

   assign syncOut = sync_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstN);

   a_sync_fixed_width: assert property ((fire && !sync_q) |=> sync_q[*4] ##1 !sync_q)
      else $error("sync pulse width wrong");
endmodule : sync_pulse_gen

// file: tb/lms_host.sv
// Purpose: Host-side model that issues list commands to the sequencer.
// Assumes: Every strobe is raised after one edge and lowered after the next.
// Notes:   Op codes: 0 dir, 1 repeat, 2 auto, 3 fixed, 4 prepare, 5 trigger, 6 sync.
`timescale 1ns/10ps
`include "lms_cfg.svh"
module lms_host
   import lms_pkg::*;
(
   input  wire logic  clk,
   output list_write_t listWr,
   output logic       dirWrite,
   output logic       dirDownSet,
   output logic       repeatWrite,
   output repeat_t    repeatSet,
   output logic       autoWrite,
   output logic       autoSet,
   output logic       fixedModeWrite,
   output logic [1:0] syncSel,
   output logic       listPrepare,
   output logic       trigger
);
   // Idle levels at time zero
   initial begin
      listWr = '0;
      {dirWrite, dirDownSet, repeatWrite, autoWrite, autoSet} = '0;
      {fixedModeWrite, listPrepare, trigger} = '0;
      repeatSet = REP_SWEEP;
      syncSel = 2'h0;
   end

   // One-cycle command strobe with its value held alongside
   task automatic cmd(input int op, input logic [31:0] v);
      @(posedge clk);
      case (op)
         0: begin dirWrite <= 1'b1; dirDownSet <= v[0]; end
         1: begin repeatWrite <= 1'b1; repeatSet <= repeat_t'(v[1:0]); end
         2: begin autoWrite <= 1'b1; autoSet <= v[0]; end
         3: fixedModeWrite <= 1'b1;
         4: listPrepare <= 1'b1;
         5: trigger <= 1'b1;
         default: syncSel <= v[1:0];
      endcase
      @(posedge clk);
      {dirWrite, repeatWrite, autoWrite, fixedModeWrite, listPrepare, trigger} <= '0;
      #1;
   endtask : cmd

   // Append one entry to a list, or empty it
   task automatic push(input list_kind_t k, input logic [31:0] d, input logic clr);
      @(posedge clk);
      listWr <= '{valid: 1'b1, clear: clr, kind: k, data: d};
      @(posedge clk);
      listWr.valid <= 1'b0;
      #1;
   endtask : push
endmodule : lms_host

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the list-mode point sequencer.
// Assumes: Dwell entry 0 is 1 us, so points are 21 cycles apart.
// Notes:   Random list contents from a fixed seed.
`timescale 1ns/10ps
`include "lms_cfg.svh"
module tb_top
   import lms_pkg::*;
;
   localparam int DW = 20;
   logic        clk, nrst;
   list_write_t listWr;
   logic        dirWrite, dirDownSet, repeatWrite, autoWrite, autoSet;
   logic        fixedModeWrite, listPrepare, trigger, dirDown, autoSeq, listMode;
   logic        pointStrobe, busy, syncOut;
   repeat_t     repeatSet, repeatMode;
   logic [1:0]  syncSel;
   logic [4:0]  freqCount, powCount, dwellCount, seqCount;
   logic [3:0]  pointIdx;
   point_t      pointOut;
   logic [31:0] fr [16];
   logic [31:0] pw [16];
   int          sub [16];
   int          fails, nCompared, syncHigh, cyc, n, m;

   lms_host i_lms_host (.clk(clk), .listWr(listWr), .dirWrite(dirWrite),
      .dirDownSet(dirDownSet), .repeatWrite(repeatWrite), .repeatSet(repeatSet),
      .autoWrite(autoWrite), .autoSet(autoSet), .fixedModeWrite(fixedModeWrite),
      .syncSel(syncSel), .listPrepare(listPrepare), .trigger(trigger));

   list_mode_sequencer i_list_mode_sequencer (.clk(clk), .nrst(nrst), .listWr(listWr),
      .dirWrite(dirWrite), .dirDownSet(dirDownSet), .repeatWrite(repeatWrite),
      .repeatSet(repeatSet), .autoWrite(autoWrite), .autoSet(autoSet),
      .fixedModeWrite(fixedModeWrite), .syncSel(syncSel), .listPrepare(listPrepare),
      .trigger(trigger), .dirDown(dirDown), .repeatMode(repeatMode), .autoSeq(autoSeq),
      .listMode(listMode), .freqCount(freqCount), .powCount(powCount),
      .dwellCount(dwellCount), .seqCount(seqCount), .pointOut(pointOut),
      .pointIdx(pointIdx), .pointStrobe(pointStrobe), .busy(busy), .syncOut(syncOut));

   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   always @(posedge clk) if (syncOut === 1'b1) syncHigh <= syncHigh + 1;

   task automatic give_verdict();
      if (fails == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic check(input bit ok, input string msg);
      nCompared++;
      if (!ok) begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : check

   // Walk position to list slot, from the settings the host last wrote
   function automatic int expSlot(input int p, input int len);
      int w;
      w = (dirDownSet === 1'b1) ? len - 1 - p : p;
      return (autoSet === 1'b1) ? w : sub[w] - 1;
   endfunction : expSlot

   function automatic logic expSync(input int p, input int len);
      case (syncSel)
         2'h0: return 1'b0;
         2'h1: return p == 0;
         2'h2: return p == len - 1;
         default: return 1'b1;
      endcase
   endfunction : expSync

   // Follow cnt points starting at walk position p0
   task automatic expectRun(input int p0, input int cnt, input int len);
      int gap, p, s;
      for (int k = 0; k < cnt; k++) begin
         p = (p0 + k) % len;
         gap = 0;
         do begin
            @(posedge clk);
            #1;
            gap++;
         end while (pointStrobe !== 1'b1 && gap < DW + 5);
         check(pointStrobe === 1'b1, "point missing");
         if (k > 0) check(gap == DW + 1, "dwell length");
         s = expSlot(p, len);
         check(pointIdx === 4'(s), "point slot");
         check(pointOut === {fr[s], pw[s]}, "point value");
         check(syncOut === expSync(p, len), "sync at point start");
      end
   endtask : expectRun

   task automatic waitIdle();
      int g;
      g = 0;
      while (busy !== 1'b0 && g < 40) begin
         @(posedge clk);
         #1;
         g++;
         check(pointStrobe !== 1'b1, "extra point");
      end
      check(busy === 1'b0, "run did not halt");
   endtask : waitIdle

   task automatic sweep(input int len);
      int exp;
      exp = (syncSel == 2'h0) ? 0 : (syncSel == 2'h3) ? len : 1;
      syncHigh = 0;
      i_lms_host.cmd(5, 0);
      expectRun(0, len, len);
      waitIdle();
      repeat (6) @(posedge clk);
      #1;
      check(syncHigh == 4 * exp, "sync pulse count");
   endtask : sweep

   initial begin
      {nrst, fails, nCompared, syncHigh, cyc} = '0;
      void'($urandom(32'h38574BBE));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(dirDown === 1'b0 && repeatMode === REP_SWEEP, "reset settings");
      check(autoSeq === 1'b1 && listMode === 1'b0 && busy === 1'b0, "reset mode");
      n = 2 + $urandom % 3;
      for (int k = 0; k < n; k++) begin
         fr[k] = $urandom;
         pw[k] = $urandom;
         i_lms_host.push(KIND_FREQ, fr[k], 1'b0);
         i_lms_host.push(KIND_POW, pw[k], 1'b0);
      end
      i_lms_host.push(KIND_DWELL, 32'h1, 1'b0);
      i_lms_host.push(KIND_DWELL, 32'h2 + $urandom % 50, 1'b0);
      check(freqCount === 5'(n) && powCount === 5'(n), "list counts");
      check(dwellCount === 5'h2, "dwell count");
      // Trigger outside list operation is ignored
      i_lms_host.cmd(5, 0);
      repeat (4) @(posedge clk);
      #1;
      check(busy === 1'b0, "run outside list mode");
      i_lms_host.cmd(2, 1);
      check(listMode === 1'b1 && autoSeq === 1'b1, "auto write");
      i_lms_host.cmd(4, 0);
      // Sweep up under sync choices 0 and 1, down under 2 and 3
      for (int s = 0; s < 4; s++) begin
         i_lms_host.cmd(6, s);
         i_lms_host.cmd(0, s / 2);
         check(dirDown === 1'(s / 2), "direction readback");
         sweep(n);
      end
      i_lms_host.cmd(1, 1);
      check(repeatMode === REP_STEP, "step readback");
      for (int k = 0; k <= n; k++) begin
         i_lms_host.cmd(5, 0);
         expectRun(k % n, 1, n);
         waitIdle();
      end
      i_lms_host.cmd(1, 2);
      check(repeatMode === REP_ENDLESS_LOOP, "loop readback");
      i_lms_host.cmd(5, 0);
      expectRun(0, 2 * n + 1, n);
      // Trigger during a running loop is ignored; the walk goes on
      i_lms_host.cmd(5, 0);
      expectRun(1, 1, n);
      i_lms_host.cmd(3, 0);
      waitIdle();
      check(listMode === 1'b0, "fixed mode");
      // Sub-list runs in both directions
      i_lms_host.cmd(2, 0);
      i_lms_host.cmd(1, 0);
      check(autoSeq === 1'b0 && listMode === 1'b1, "auto off");
      i_lms_host.push(KIND_SEQ, 32'h0, 1'b1);
      check(seqCount === 5'h0, "sub-list clear");
      m = 3;
      for (int j = 0; j < m; j++) begin
         sub[j] = 1 + $urandom % n;
         i_lms_host.push(KIND_SEQ, 32'(sub[j]), 1'b0);
      end
      check(seqCount === 5'(m), "sub-list count");
      i_lms_host.cmd(0, 0);
      sweep(m);
      i_lms_host.cmd(0, 1);
      sweep(m);
      // Appends beyond the list depth are dropped
      for (int j = 0; j < 15; j++)
         i_lms_host.push(KIND_DWELL, 32'h3, 1'b0);
      check(dwellCount === 5'h10, "dwell list full");
      give_verdict();
   end
endmodule : tb_top
